// file: rtl/qdac_cfg.svh
// Constants for the quad converter two-wire slave.
// Assumes inclusion by bare name from rtl files.
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
`define QDAC_CODE_W       12
`define QDAC_NUM_CH       4
`define QDAC_ADDR_HI6     6'h1E
`define QDAC_CODE_RESET   12'h000
`define QDAC_PD_RESET     2'h3
`define QDAC_GLITCH_CYC   4'h3
`define QDAC_CMD_EXT      4'h1
`define QDAC_CMD_LOAD_ALL 2'h0
`define QDAC_CMD_LOAD_IN  2'h1
`define QDAC_CMD_UPD_ALL  4'h8
`define QDAC_CMD_LOAD_ALL_IN 4'hC
`endif

// file: rtl/qdac_pkg.sv
// Types for the quad converter two-wire slave.
// Assumes qdac_cfg.svh for numeric constants.
package qdac_pkg;
  typedef enum logic [1:0] {
    QDAC_PD_ON, QDAC_PD_FLOAT, QDAC_PD_1K, QDAC_PD_100K
  } qdac_pd_t;
  typedef enum logic [2:0] {
    QDAC_ST_IDLE, QDAC_ST_ADDR, QDAC_ST_ACK, QDAC_ST_WR, QDAC_ST_RD, QDAC_ST_RACK
  } qdac_state_t;
endpackage

// file: rtl/qdac_line_filter.sv
// Synchroniser and glitch filter for one bus line.
// Assumes the line idles high and is asynchronous to clk.
`timescale 1ns/1ps
`include "qdac_cfg.svh"
module qdac_line_filter #(
  parameter logic [3:0] FILT_CYC = `QDAC_GLITCH_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic line_in,
  output logic      line_out
);
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       out_r;
  logic       out_nxt;

  always_comb begin
    sync_nxt = {sync_r[0], line_in};
    cnt_nxt  = 4'h0;
    out_nxt  = out_r;
    // Output follows only after the level holds for FILT_CYC samples
    if (sync_r[1] != out_r) begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r >= FILT_CYC - 4'h1) begin
        out_nxt = sync_r[1];
        cnt_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_r <= 2'h3;
      cnt_r  <= 4'h0;
      out_r  <= 1'b1;
    end else begin
      sync_r <= sync_nxt;
      cnt_r  <= cnt_nxt;
      out_r  <= out_nxt;
    end
  end

  assign line_out = out_r;
endmodule

// file: rtl/qdac_slave.sv
// Two-wire slave and register core of a quad 12-bit converter.
// Assumes an external master drives scl; sda is open drain, resolved outside.
// Functional notes
// - Each of four channels has its own input and output register.
// - Output register writes change output now; input-only writes do not.
// - Register contents are never cleared by idle or timeout.
// - Codes are unsigned straight binary, zero to 4095.
// - Reset clears output registers and selects 100k power-down everywhere.
// - Power-down disables buffers and disconnects strings from reference.
// - Select 00 up, 01 float, 10 1k, 11 100k.
// - Power-down keeps registers; wake-up restores prior output.
// - Address least bit follows the address-select pin.
// - Slave only; never drives the clock line.
// - Works for bus rates from static up to 400kHz.
// - Bytes are eight bits, MSB first, plus an acknowledge pulse.
// - SDA change during SCL high is a control condition.
// - Lines are released when idle.
// - Start is SDA falling with SCL high; stop is SDA rising.
// - Repeated start keeps session and expects a new address.
// - Stop or address mismatch ignores clock until next start.
// - Stop honoured anywhere except same high pulse as start.
// - Back-to-back writes accepted with or without repeated start.
// - Acknowledge received bytes by holding SDA low in ninth period.
// - Address last bit: zero write, one read.
// - Registers update at acknowledge falling edge; aborted writes change nothing.
// - General call ignored; seven-bit addressing only.
`timescale 1ns/1ps
`include "qdac_cfg.svh"
module qdac_slave
  import qdac_pkg::*;
#(
  parameter logic [5:0] ADDR_HI6 = `QDAC_ADDR_HI6,
  parameter int         CODE_W   = `QDAC_CODE_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic              addr_sel,
  output logic [CODE_W-1:0]      chan_a_output,
  output logic [CODE_W-1:0]      chan_b_output,
  output logic [CODE_W-1:0]      chan_c_output,
  output logic [CODE_W-1:0]      chan_d_output,
  output logic [3:0]             buf_enable,
  output logic [3:0]             term_1k,
  output logic [3:0]             term_100k,
  output logic                   bus_active
);
  // ****************************************
  // Line conditioning
  // ****************************************
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;
  logic [1:0] asel_sync_r;

  qdac_line_filter u_scl_filt (
    .clk      (clk),
    .reset    (reset),
    .line_in  (scl_in),
    .line_out (scl_f)
  );
  qdac_line_filter u_sda_filt (
    .clk      (clk),
    .reset    (reset),
    .line_in  (sda_in),
    .line_out (sda_f)
  );

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_f & ~scl_d_r;
  assign scl_fall  = ~scl_f & scl_d_r;
  assign start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic qdac_pd_t pd_decode(input logic [1:0] sel);
    // Bit 1 is powerdown_sel_hi, bit 0 powerdown_sel_lo
    case (sel)
      2'h0:    pd_decode = QDAC_PD_ON;
      2'h1:    pd_decode = QDAC_PD_FLOAT;
      2'h2:    pd_decode = QDAC_PD_1K;
      default: pd_decode = QDAC_PD_100K;
    endcase
  endfunction

  // ****************************************
  // Protocol and register state
  // ****************************************
  qdac_state_t       st_r, st_nxt;
  qdac_state_t       ack_ret_r, ack_ret_nxt;
  logic [7:0]        sh_r, sh_nxt;
  logic [3:0]        bit_r, bit_nxt;
  logic [1:0]        byte_r, byte_nxt;
  logic [7:0]        cmd_r, cmd_nxt;
  logic              ext_r, ext_nxt;
  logic              ack_drv_r, ack_drv_nxt;
  logic              tx_r, tx_nxt;
  logic              started_r, started_nxt;
  logic              nack_r, nack_nxt;
  logic [1:0]        rd_ch_r, rd_ch_nxt;
  logic [CODE_W-1:0] in_r  [`QDAC_NUM_CH];
  logic [CODE_W-1:0] in_nxt[`QDAC_NUM_CH];
  logic [CODE_W-1:0] out_r [`QDAC_NUM_CH];
  logic [CODE_W-1:0] out_nxt[`QDAC_NUM_CH];
  qdac_pd_t          pd_r  [`QDAC_NUM_CH];
  qdac_pd_t          pd_nxt[`QDAC_NUM_CH];

  logic [6:0] own_addr;
  assign own_addr = {ADDR_HI6, asel_sync_r[1]};

  always_comb begin
    st_nxt      = st_r;
    ack_ret_nxt = ack_ret_r;
    sh_nxt      = sh_r;
    bit_nxt     = bit_r;
    byte_nxt    = byte_r;
    cmd_nxt     = cmd_r;
    ext_nxt     = ext_r;
    ack_drv_nxt = ack_drv_r;
    tx_nxt      = tx_r;
    started_nxt = started_r;
    nack_nxt    = nack_r;
    rd_ch_nxt   = rd_ch_r;
    in_nxt      = in_r;
    out_nxt     = out_r;
    pd_nxt      = pd_r;
    if (start_det) begin
      st_nxt      = QDAC_ST_ADDR;
      bit_nxt     = 4'h0;
      byte_nxt    = 2'h0;
      ext_nxt     = 1'b0;
      ack_drv_nxt = 1'b0;
      tx_nxt      = 1'b0;
      started_nxt = 1'b1;
    end else if (stop_det && !started_r) begin
      st_nxt      = QDAC_ST_IDLE;
      ack_drv_nxt = 1'b0;
      tx_nxt      = 1'b0;
    end else begin
      if (scl_rise) begin
        started_nxt = 1'b0;
      end
      case (st_r)
        QDAC_ST_IDLE: begin
          // Clock ignored here, lines left released
        end
        QDAC_ST_ADDR, QDAC_ST_WR: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_f};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            if (st_r == QDAC_ST_ADDR) begin
              if (sh_r[7:1] == own_addr) begin
                ack_drv_nxt = 1'b1;
                ack_ret_nxt = sh_r[0] ? QDAC_ST_RD : QDAC_ST_WR;
                // Marks the address ack so it is not taken as a command
                byte_nxt    = 2'h2;
                st_nxt      = QDAC_ST_ACK;
              end else begin
                st_nxt = QDAC_ST_IDLE;
              end
            end else begin
              ack_drv_nxt = 1'b1;
              ack_ret_nxt = QDAC_ST_WR;
              st_nxt      = QDAC_ST_ACK;
            end
          end
        end
        QDAC_ST_ACK: begin
          if (scl_fall) begin
            ack_drv_nxt = 1'b0;
            st_nxt      = ack_ret_r;
            if (ack_ret_r == QDAC_ST_RD) begin
              rd_ch_nxt = cmd_r[5:4];
              sh_nxt    = {4'h0, out_r[cmd_r[5:4]][CODE_W-1:8]};
              tx_nxt    = 1'b1;
              byte_nxt  = 2'h0;
            end else if (byte_r == 2'h2) begin
              // Address acknowledged; a command byte comes next
              byte_nxt = 2'h0;
            end else if (byte_r == 2'h0) begin
              cmd_nxt  = sh_r;
              ext_nxt  = (sh_r[7:4] == `QDAC_CMD_EXT) && (sh_r[3:0] == 4'h0);
              byte_nxt = 2'h1;
            end else begin
              byte_nxt = 2'h0;
              ext_nxt  = 1'b0;
              if (ext_r) begin
                // Power-down byte: select in bits 7:6, channels D..A in 5:2
                for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                  if (sh_r[2+i]) begin
                    pd_nxt[i] = pd_decode(sh_r[7:6]);
                  end
                end
              end else if (cmd_r[7:6] == `QDAC_CMD_LOAD_ALL) begin
                // Load one, transfer all inputs to outputs
                for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                  out_nxt[i] = in_r[i];
                end
                in_nxt[cmd_r[5:4]]  = {cmd_r[3:0], sh_r};
                out_nxt[cmd_r[5:4]] = {cmd_r[3:0], sh_r};
              end else if (cmd_r[7:6] == `QDAC_CMD_LOAD_IN) begin
                in_nxt[cmd_r[5:4]] = {cmd_r[3:0], sh_r};
              end else if (cmd_r[7:4] == `QDAC_CMD_UPD_ALL) begin
                for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                  out_nxt[i] = in_r[i];
                end
              end else if (cmd_r[7:4] == `QDAC_CMD_LOAD_ALL_IN) begin
                for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                  in_nxt[i] = {cmd_r[3:0], sh_r};
                end
              end
            end
          end
        end
        QDAC_ST_RD: begin
          if (scl_fall && bit_r != 4'h8) begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              tx_nxt  = 1'b0;
              bit_nxt = 4'h8;
            end
          end
          if (scl_rise && bit_r == 4'h8) begin
            nack_nxt = sda_f;
            st_nxt   = QDAC_ST_RACK;
          end
        end
        QDAC_ST_RACK: begin
          if (scl_fall) begin
            bit_nxt = 4'h0;
            if (nack_r) begin
              st_nxt = QDAC_ST_IDLE;
            end else begin
              st_nxt   = QDAC_ST_RD;
              tx_nxt   = 1'b1;
              byte_nxt = byte_r + 2'h1;
              sh_nxt   = byte_r[0] ? {4'h0, out_r[rd_ch_r][CODE_W-1:8]}
                                   : out_r[rd_ch_r][7:0];
            end
          end
        end
        default: st_nxt = QDAC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r        <= QDAC_ST_IDLE;
      ack_ret_r   <= QDAC_ST_IDLE;
      sh_r        <= 8'h00;
      bit_r       <= 4'h0;
      byte_r      <= 2'h0;
      cmd_r       <= 8'h00;
      ext_r       <= 1'b0;
      ack_drv_r   <= 1'b0;
      tx_r        <= 1'b0;
      started_r   <= 1'b0;
      nack_r      <= 1'b0;
      rd_ch_r     <= 2'h0;
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      asel_sync_r <= 2'h0;
      for (int i = 0; i < `QDAC_NUM_CH; i++) begin
        in_r[i]  <= `QDAC_CODE_RESET;
        out_r[i] <= `QDAC_CODE_RESET;
        pd_r[i]  <= QDAC_PD_100K;
      end
    end else begin
      st_r        <= st_nxt;
      ack_ret_r   <= ack_ret_nxt;
      sh_r        <= sh_nxt;
      bit_r       <= bit_nxt;
      byte_r      <= byte_nxt;
      cmd_r       <= cmd_nxt;
      ext_r       <= ext_nxt;
      ack_drv_r   <= ack_drv_nxt;
      tx_r        <= tx_nxt;
      started_r   <= started_nxt;
      nack_r      <= nack_nxt;
      rd_ch_r     <= rd_ch_nxt;
      scl_d_r     <= scl_f;
      sda_d_r     <= sda_f;
      asel_sync_r <= {asel_sync_r[0], addr_sel};
      in_r        <= in_nxt;
      out_r       <= out_nxt;
      pd_r        <= pd_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: only ever pulls low, never touches scl
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drv_r | (tx_r & ~sh_r[7]);
  assign bus_active = (st_r != QDAC_ST_IDLE);

  assign chan_a_output = out_r[0];
  assign chan_b_output = out_r[1];
  assign chan_c_output = out_r[2];
  assign chan_d_output = out_r[3];

  genvar g;
  generate
    for (g = 0; g < `QDAC_NUM_CH; g++) begin : g_pd
      // Buffer off disconnects string from reference too
      assign buf_enable[g] = (pd_r[g] == QDAC_PD_ON);
      assign term_1k[g]    = (pd_r[g] == QDAC_PD_1K);
      assign term_100k[g]  = (pd_r[g] == QDAC_PD_100K);
    end
  endgenerate
endmodule

// file: bench/qdac_slave_props.sv
// Port checker for the quad converter two-wire slave.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module qdac_slave_props #(
  parameter int CODE_W = 12
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_oe,
  input wire logic [CODE_W-1:0] chan_a_output,
  input wire logic [CODE_W-1:0] chan_b_output,
  input wire logic [CODE_W-1:0] chan_c_output,
  input wire logic [CODE_W-1:0] chan_d_output,
  input wire logic [3:0]        buf_enable,
  input wire logic [3:0]        term_1k,
  input wire logic [3:0]        term_100k,
  input wire logic              bus_active
);
  default clocking cb @(posedge clk); endclocking
  reset_out_a: assert property (reset |=> chan_a_output == '0 && chan_d_output == '0
    && buf_enable == 4'h0 && term_100k == 4'hF && !sda_oe) else $error("reset state wrong");
  term_excl_a: assert property (disable iff (reset) (term_1k & term_100k) == 4'h0)
    else $error("two terminations on one channel");
  buf_term_a: assert property (disable iff (reset) (buf_enable & (term_1k | term_100k)) == 4'h0)
    else $error("buffer on while terminated");
  drive_idle_a: assert property (disable iff (reset) sda_oe |-> bus_active)
    else $error("sda driven while idle");
  start_det_a: assert property (disable iff (reset)
    $fell(sda_in) && scl_in && !bus_active |-> ##[2:10] bus_active) else $error("start missed");
  stop_det_a: assert property (disable iff (reset)
    $rose(sda_in) && scl_in |-> ##[2:10] !bus_active) else $error("stop missed");
  upd_active_a: assert property (disable iff (reset)
    $changed({chan_a_output, chan_b_output, chan_c_output, chan_d_output, buf_enable,
    term_1k, term_100k}) |-> bus_active) else $error("state changed outside transfer");
  ack_hold_a: assert property (disable iff (reset) $rose(sda_oe) |-> sda_oe [*6])
    else $error("sda low too short");
  addr_quiet_a: assert property (disable iff (reset) $rose(bus_active) |-> !sda_oe [*8])
    else $error("sda driven during address");
endmodule
bind qdac_slave qdac_slave_props #(.CODE_W(CODE_W)) qdac_slave_props_i (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
  .chan_a_output(chan_a_output), .chan_b_output(chan_b_output),
  .chan_c_output(chan_c_output), .chan_d_output(chan_d_output), .buf_enable(buf_enable),
  .term_1k(term_1k), .term_100k(term_100k), .bus_active(bus_active));

// file: bench/qdac_bus_master.sv
// Two-wire bus master model driving the slave's bus lines.
// Assumes a pulled-up sda wire built from both parties' enables.
`timescale 1ns/1ps
module qdac_bus_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // ****************
  // Bit timing
  // ****************
  // Low phase stretched so the filtered ack settles before scl rises
  localparam int T_HI = 32;
  localparam int T_LO = 96;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end
  task automatic bit_out(input logic b);
    #(T_LO / 4) sda_drv = !b;
    #(T_LO * 3 / 4) scl = 1'b1;
    #T_HI scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #(T_LO / 4) sda_drv = 1'b0;
    #(T_LO * 3 / 4) scl = 1'b1;
    #(T_HI - 4) b = sda;
    #4 scl = 1'b0;
  endtask
  task automatic start();
    #(T_LO / 4) sda_drv = 1'b0;
    #(T_LO * 3 / 4) scl = 1'b1;
    #T_HI sda_drv = 1'b1;
    #T_HI scl = 1'b0;
  endtask
  task automatic stop();
    #(T_LO / 4) sda_drv = 1'b1;
    #(T_LO * 3 / 4) scl = 1'b1;
    #T_HI sda_drv = 1'b0;
    #T_HI;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = !a;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the quad converter two-wire slave.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
`include "qdac_cfg.svh"
module testbench;
  localparam logic [7:0] ADW = {`QDAC_ADDR_HI6, 2'b10};
  localparam logic [7:0] ADR = {`QDAC_ADDR_HI6, 2'b11};
  logic        clk;
  logic        reset;
  logic        addr_sel;
  logic        scl;
  logic        m_drv;
  logic        sda_out;
  logic        sda_oe;
  logic        bus_active;
  logic [11:0] ch_a, ch_b, ch_c, ch_d;
  logic [3:0]  buf_en, t1k, t100k;
  wire         sda = !m_drv && (sda_oe ? sda_out : 1'b1);
  int          bad_count;
  int          checked;
  qdac_slave qdac_slave_i (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .chan_a_output(ch_a),
    .chan_b_output(ch_b), .chan_c_output(ch_c), .chan_d_output(ch_d), .buf_enable(buf_en),
    .term_1k(t1k), .term_100k(t100k), .bus_active(bus_active));
  qdac_bus_master qdac_bus_master_i (.scl(scl), .sda_drv(m_drv), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic open_dev(input logic [7:0] a, input logic exp);
    logic ak;
    qdac_bus_master_i.start();
    qdac_bus_master_i.wr_byte(a, ak);
    chk("addr ack", {11'h0, exp}, {11'h0, ak});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic exp);
    logic ak;
    qdac_bus_master_i.wr_byte(c, ak);
    chk("cmd ack", {11'h0, exp}, {11'h0, ak});
    qdac_bus_master_i.wr_byte(d, ak);
    chk("data ack", {11'h0, exp}, {11'h0, ak});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk("codes", 12'h000, ch_a | ch_b | ch_c | ch_d);
    chk("power", 12'h00F, {buf_en, t1k, t100k});
  endtask
  task automatic t_load();
    open_dev(ADW, 1'b1);
    wr(8'h0A, 8'hBC, 1'b1);
    wr(8'h5F, 8'hFF, 1'b1);
    qdac_bus_master_i.stop();
    chk("load a", 12'hABC, ch_a);
    chk("input b", 12'h000, ch_b);
    open_dev(ADW, 1'b1);
    wr(8'h80, 8'h00, 1'b1);
    qdac_bus_master_i.stop();
    chk("update b", 12'hFFF, ch_b);
    chk("update cd", 12'h000, ch_c | ch_d);
  endtask
  task automatic t_power();
    logic [1:0] pd;
    open_dev(ADW, 1'b1);
    wr(8'h10, 8'h04, 1'b1);
    qdac_bus_master_i.stop();
    chk("wake a", 12'h10E, {buf_en, t1k, t100k});
    for (int i = 1; i < 5; i++) begin
      pd = i[1:0];
      open_dev(ADW, 1'b1);
      wr(8'h10, {pd, 6'h3C}, 1'b1);
      qdac_bus_master_i.stop();
      chk("pd mode", {(pd == 0) ? 4'hF : 4'h0, (pd == 2) ? 4'hF : 4'h0,
        (pd == 3) ? 4'hF : 4'h0}, {buf_en, t1k, t100k});
    end
    chk("restore a", 12'hABC, ch_a);
  endtask
  task automatic t_addr();
    open_dev({`QDAC_ADDR_HI6, 2'b00}, 1'b0);
    wr(8'h0F, 8'hFF, 1'b0);
    qdac_bus_master_i.stop();
    chk("ignored a", 12'hABC, ch_a);
    open_dev(8'h00, 1'b0);
    qdac_bus_master_i.stop();
    @(posedge clk) #1 addr_sel = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    open_dev({`QDAC_ADDR_HI6, 2'b00}, 1'b1);
    qdac_bus_master_i.stop();
    @(posedge clk) #1 addr_sel = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_abort();
    logic ak;
    open_dev(ADW, 1'b1);
    qdac_bus_master_i.wr_byte(8'h01, ak);
    qdac_bus_master_i.stop();
    chk("abort a", 12'hABC, ch_a);
  endtask
  task automatic t_rstart();
    logic [7:0] hi, lo;
    open_dev(ADW, 1'b1);
    wr(8'h0C, 8'hDE, 1'b1);
    open_dev(ADW, 1'b1);
    wr(8'h3D, 8'h21, 1'b1);
    // Registers load a few clocks after the raw scl fall
    #80;
    chk("chain a", 12'hCDE, ch_a);
    chk("chain d", 12'hD21, ch_d);
    open_dev(ADR, 1'b1);
    qdac_bus_master_i.rd_byte(1'b0, hi);
    qdac_bus_master_i.rd_byte(1'b1, lo);
    qdac_bus_master_i.stop();
    chk("read d", 12'hD21, {hi[3:0], lo});
    chk("kept d", 12'hD21, ch_d);
  endtask
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    addr_sel = 1'b1;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    t_reset();
    t_load();
    t_power();
    t_addr();
    t_abort();
    t_rstart();
    end_sim();
  end
endmodule
